// ===== bench/bus_master.sv
// Two-wire bus master model that makes the bus clock and pulls the data line
`timescale 1ns/100ps
module bus_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      pull
);
    // Bus idles with clock high and data released
    initial begin
        scl  = 1'b1;
        pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waits a fixed number of system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Start or repeated start: data falls while clock is high
    task automatic start();
        pull <= 1'b0;
        tick(4);
        scl  <= 1'b1;
        tick(4);
        pull <= 1'b1;
        tick(4);
        scl  <= 1'b0;
        tick(4);
    endtask : start

    // One bit: data set while clock is low, sampled in mid high phase
    task automatic bit_cycle(input logic b, output logic r);
        pull <= ~b;
        tick(4);
        scl  <= 1'b1;
        tick(4);
        r = sda;
        tick(4);
        scl  <= 1'b0;
        tick(4);
    endtask : bit_cycle

    // Eight bits most significant first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], q[i]);
        end
        bit_cycle(1'b1, r);
        ack = ~r;
    endtask : xfer

    // Stop: data rises while clock is high, bus left idle
    task automatic stop();
        pull <= 1'b1;
        tick(4);
        scl  <= 1'b1;
        tick(4);
        pull <= 1'b0;
        tick(8);
    endtask : stop
endmodule : bus_master

// ===== bench/tb.sv
// Self-checking bench for the dual potentiometer two-wire slave
`timescale 1ns/100ps
`include "dual_pot_map.svh"
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end
module tb;
    localparam logic [3:0] TYPE_ID = 4'h3; // Arbitrary value
    localparam logic [3:0] STRAP   = 4'h6;
    logic               REF_CLK;
    logic               RESET;
    logic               WRITE_PROTECT_N;
    logic [3:0]         ADDRESS_STRAP_PINS;
    logic               scl;
    logic               pull;
    logic               sda_oe;
    logic               sda_out;
    logic               sda;
    dual_pot_pkg::tap_t tap0;
    dual_pot_pkg::tap_t tap1;
    int                 n_fail = 0;
    int                 n_compared = 0;

    // Pull-up holds the wire high unless someone pulls it low
    assign sda = ~(sda_oe | pull);

    dual_pot_slave #(.NV_WRITE_CYCLES(200), .DEVICE_TYPE_ID(TYPE_ID)) u_dut (
        .REF_CLK(REF_CLK), .RESET(RESET), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .ADDRESS_STRAP_PINS(ADDRESS_STRAP_PINS),
        .WRITE_PROTECT_N(WRITE_PROTECT_N), .TAP_SELECT_0(tap0), .TAP_SELECT_1(tap1));
    bus_master u_master (.clk(REF_CLK), .sda(sda), .scl(scl), .pull(pull));

    ////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run
    task automatic give_verdict();
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // One frame: address, instruction, then a data byte written or read
    task automatic frame(input logic [3:0] adr, input logic [7:0] ins, input logic [7:0] dat,
                         input logic rd, output logic [7:0] q, output logic [2:0] ak);
        logic [7:0] t;
        ak = 3'h0;
        q  = 8'h00;
        u_master.start();
        u_master.xfer({TYPE_ID, adr}, t, ak[2]);
        if (ak[2]) begin
            u_master.xfer(ins, t, ak[1]);
            if (rd) u_master.xfer(8'hff, q, t[0]);
            else u_master.xfer(dat, t, ak[0]);
        end
        u_master.stop();
        `CHK("open drain data level", 1'b0, sda_out)
    endtask : frame

    // Writes a wiper, checks the taps, reads it back; oth is the other pot's wiper
    task automatic t_wiper(input logic pot, input logic [7:0] val, input logic [7:0] oth);
        logic [7:0] q;
        logic [2:0] ak;
        frame(STRAP, {`OP_WR_WIPER, 3'h0, pot}, val, 1'b0, q, ak);
        `CHK("write acks", 3'h7, ak)
        `CHK("tap select", 256'h1 << val, pot ? tap1 : tap0)
        `CHK("one hot taps", 1'b1, $onehot(pot ? tap1 : tap0))
        `CHK("other pot taps", 256'h1 << oth, pot ? tap0 : tap1)
        frame(STRAP, {`OP_RD_WIPER, 3'h0, pot}, 8'h00, 1'b1, q, ak);
        `CHK("read acks", 3'h6, ak)
        `CHK("wiper read back", val, q)
    endtask : t_wiper

    // Foreign address is ignored
    task automatic t_addr();
        logic [7:0] q;
        logic [2:0] ak;
        frame(STRAP ^ 4'h8, {`OP_WR_WIPER, 4'h0}, 8'h33, 1'b0, q, ak);
        `CHK("foreign address ack", 3'h0, ak)
        `CHK("taps after foreign frame", 256'h1 << 8'hff, tap0)
    endtask : t_addr

    // Stored write blocked, then allowed with acknowledge polling
    task automatic t_stored();
        logic [7:0] q;
        logic [2:0] ak;
        WRITE_PROTECT_N <= 1'b0;
        frame(STRAP, {`OP_WR_STORED, 4'h2}, 8'h5a, 1'b0, q, ak);
        frame(STRAP, {`OP_RD_STORED, 4'h2}, 8'h00, 1'b1, q, ak);
        `CHK("protected stored", 8'h00, q)
        WRITE_PROTECT_N <= 1'b1;
        frame(STRAP, {`OP_WR_STORED, 4'h2}, 8'h5a, 1'b0, q, ak);
        frame(STRAP, {`OP_RD_STORED, 4'h2}, 8'h00, 1'b1, q, ak);
        `CHK("busy address ack", 1'b0, ak[2])
        for (int i = 0; i < 40 && !ak[2]; i++) begin
            frame(STRAP, {`OP_RD_STORED, 4'h2}, 8'h00, 1'b1, q, ak);
        end
        if (!ak[2]) begin
            n_fail++;
            give_verdict();
        end
        `CHK("stored read back", 8'h5a, q)
        // Stored setting to wiper: no data byte, so the third byte goes unacknowledged
        frame(STRAP, {`OP_XFR_TO_WIPER, 4'h2}, 8'h00, 1'b0, q, ak);
        `CHK("transfer acks", 3'h6, ak)
        `CHK("tap after transfer", 256'h1 << 8'h5a, tap0)
        // Global transfer loads both wipers from their first stored setting
        frame(STRAP, {`OP_GXFR_TO_WIPER, 4'h0}, 8'h00, 1'b0, q, ak);
        `CHK("global transfer acks", 3'h6, ak)
        `CHK("pot 0 after global", 256'h1 << 8'h5a, tap0)
        `CHK("pot 1 after global", 256'h1, tap1)
    endtask : t_stored

    // Free running system clock
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    // Main sequence
    initial begin
        RESET              = 1'b1;
        WRITE_PROTECT_N    = 1'b1;
        ADDRESS_STRAP_PINS = STRAP;
        repeat (6) @(posedge REF_CLK);
        RESET <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        `CHK("taps after reset", 256'h1, tap0)
        t_wiper(1'b1, 8'h80, 8'h00);
        t_wiper(1'b0, 8'hff, 8'h80);
        t_addr();
        t_stored();
        give_verdict();
    end
endmodule : tb

// ===== hw/dual_pot_map.svh
// Opcodes, field positions, reset values and timing of the dual potentiometer slave
`ifndef DUAL_POT_MAP_SVH
`define DUAL_POT_MAP_SVH
// Instruction byte fields
`define OP_MSB          7
`define OP_LSB          4
`define SEL_MSB         3
`define SEL_LSB         2
`define POT_BIT         0
// Identification byte fields
`define TYPE_MSB        7
`define TYPE_LSB        4
`define ADDR_MSB        3
`define ADDR_LSB        0
// Instruction opcodes
`define OP_RD_WIPER     4'h9
`define OP_WR_WIPER     4'ha
`define OP_RD_STORED    4'hb
`define OP_WR_STORED    4'hc
`define OP_XFR_TO_WIPER 4'hd
`define OP_XFR_TO_STORE 4'he
`define OP_GXFR_TO_WIPER 4'h1
`define OP_GXFR_TO_STORE 4'h8
// Reset values
`define WIPER_RESET     8'h00
`define STORED_RESET    8'h00
`define TAP_RESET       256'h1
// Nonvolatile write time and its length in clock cycles
`define NV_WRITE_TIME_NS 5000000
`define CLK_PERIOD_NS   10
`define NV_WRITE_CYCLES (`NV_WRITE_TIME_NS / `CLK_PERIOD_NS)
`define NV_CNT_W        20
`endif

// ===== hw/dual_pot_pkg.sv
// Types shared by the dual potentiometer slave
package dual_pot_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK  = 5'h04,
        ST_SEND = 5'h08,
        ST_HOLD = 5'h10
    } link_state_e;
    typedef enum logic [2:0] {
        PH_ID   = 3'h1,
        PH_INST = 3'h2,
        PH_DATA = 3'h4
    } phase_e;
    typedef logic [7:0]   byte_t;
    typedef logic [255:0] tap_t;
endpackage : dual_pot_pkg

// ===== hw/dual_pot_slave.sv
// Two-wire slave and tap selection of a dual digital potentiometer
//
// How it works
// R1: Input bits sampled on clock rise; own data changed only after clock fall.
// R2: Data line is only pulled low or released, never driven high.
// R3: Four address strap pins form the low four bits of the address byte.
// R4: Transfer proceeds only when received address bits match the straps.
// R5: Write protect low blocks every nonvolatile stored-setting write.
// R6: At most one tap switch per potentiometer is enabled.
// R7: Eight-bit wiper position decodes to exactly one of 256 taps.
// R8: Two independent potentiometers, each with its own wiper position.
// R9: Wiper position and stored settings are readable and writable over the bus.
// R10: The master starts transfers and supplies the clock; device is slave only.
// R11: Data changes only while clock is low, stable while it is high.
// R12: Data edges while clock is high are start or stop, never data.
// R13: Start is data falling while clock high; nothing is obeyed before it.
// R14: The master ends every communication with a stop.
// R15: Acknowledge after matching address, after command, after following data byte.
// R16: After nonvolatile write and stop, address is not acknowledged until done.
`timescale 1ns/100ps
`include "dual_pot_map.svh"
module dual_pot_slave #(
    parameter int unsigned NV_WRITE_CYCLES = `NV_WRITE_CYCLES,
    parameter logic [3:0]  DEVICE_TYPE_ID  = 4'h3  // Arbitrary value
) (
    input  wire logic                  REF_CLK,
    input  wire logic                  RESET,
    input  wire logic                  SCL,
    input  wire logic                  SDA_IN,
    output wire logic                  SDA_OUT,
    output wire logic                  SDA_OE,
    input  wire logic [3:0]            ADDRESS_STRAP_PINS,
    input  wire logic                  WRITE_PROTECT_N,
    output wire dual_pot_pkg::tap_t    TAP_SELECT_0,
    output wire dual_pot_pkg::tap_t    TAP_SELECT_1
);
    ////////////////////////////////////////////////////////////////////////////////
    // One-hot tap decode
    function automatic dual_pot_pkg::tap_t decode_tap(input dual_pot_pkg::byte_t pos);
        dual_pot_pkg::tap_t t;
        t = '0;
        t[pos] = 1'b1;
        return t;
    endfunction : decode_tap

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge detection
    logic       scl_meta, scl_sync, scl_last;
    logic       sda_meta, sda_sync, sda_last;
    logic [3:0] strap_meta, strap_sync;
    logic       wp_meta, wp_sync;

    // Two flip-flops on every pin before use
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            {scl_meta, scl_sync, scl_last} <= 3'h7;
            {sda_meta, sda_sync, sda_last} <= 3'h7;
            strap_meta <= 4'h0;
            strap_sync <= 4'h0;
            wp_meta    <= 1'b0;
            wp_sync    <= 1'b0;
        end else begin
            scl_meta   <= SCL;  // R10
            scl_sync   <= scl_meta;
            scl_last   <= scl_sync;
            sda_meta   <= SDA_IN;
            sda_sync   <= sda_meta;
            sda_last   <= sda_sync;
            strap_meta <= ADDRESS_STRAP_PINS;
            strap_sync <= strap_meta;
            wp_meta    <= WRITE_PROTECT_N;
            wp_sync    <= wp_meta;
        end
    end

    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise   = scl_sync & ~scl_last;
    assign scl_fall   = ~scl_sync & scl_last;
    assign start_cond = scl_sync & scl_last & sda_last & ~sda_sync;  // R12 R13
    assign stop_cond  = scl_sync & scl_last & ~sda_last & sda_sync;  // R12 R14

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol engine and registers
    dual_pot_pkg::link_state_e state_reg, state_next;
    dual_pot_pkg::phase_e      phase_reg, phase_next;
    logic [2:0]          bit_reg, bit_next;
    dual_pot_pkg::byte_t shift_reg, shift_next, tx_reg, tx_next, pend_data_reg, pend_data_next;
    logic [3:0]          op_reg, op_next;
    logic [1:0]          sel_reg, sel_next;
    logic                pot_reg, pot_next, ack_reg, ack_next, oe_reg, oe_next;
    logic                more_rx_reg, more_rx_next, more_tx_reg, more_tx_next;
    logic                pend_reg, pend_next;
    dual_pot_pkg::byte_t wiper_reg [2];
    dual_pot_pkg::byte_t wiper_next [2];
    dual_pot_pkg::byte_t stored_reg [2][4];
    dual_pot_pkg::byte_t stored_next [2][4];
    logic [`NV_CNT_W-1:0] busy_reg, busy_next;
    dual_pot_pkg::byte_t rx_byte;
    logic                commit_nv;

    assign rx_byte   = {shift_reg[6:0], sda_sync};  // R1
    assign commit_nv = stop_cond & pend_reg & wp_sync;  // R5

    // Next state of the serial engine and the potentiometer registers
    always_comb begin
        state_next     = state_reg;
        phase_next     = phase_reg;
        bit_next       = bit_reg;
        shift_next     = shift_reg;
        tx_next        = tx_reg;
        pend_data_next = pend_data_reg;
        op_next        = op_reg;
        sel_next       = sel_reg;
        pot_next       = pot_reg;
        ack_next       = ack_reg;
        oe_next        = oe_reg;
        more_rx_next   = more_rx_reg;
        more_tx_next   = more_tx_reg;
        pend_next      = pend_reg;
        wiper_next     = wiper_reg;
        stored_next    = stored_reg;
        if (start_cond) begin
            state_next = dual_pot_pkg::ST_RECV;  // R13
            phase_next = dual_pot_pkg::PH_ID;
            bit_next   = 3'h0;
            oe_next    = 1'b0;
            pend_next  = 1'b0;
        end else if (stop_cond) begin
            state_next = dual_pot_pkg::ST_IDLE;
            oe_next    = 1'b0;
            pend_next  = 1'b0;
            if (commit_nv) begin
                unique case (op_reg)
                    `OP_WR_STORED:     stored_next[pot_reg][sel_reg] = pend_data_reg;  // R9
                    `OP_XFR_TO_STORE:  stored_next[pot_reg][sel_reg] = wiper_reg[pot_reg];
                    default: begin
                        stored_next[0][sel_reg] = wiper_reg[0];
                        stored_next[1][sel_reg] = wiper_reg[1];
                    end
                endcase
            end
        end else begin
            unique case (state_reg)
                dual_pot_pkg::ST_IDLE: begin
                end
                dual_pot_pkg::ST_RECV: begin
                    if (scl_rise) begin
                        shift_next = rx_byte;  // R1
                        bit_next   = bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_next = dual_pot_pkg::ST_ACK;
                            unique case (phase_reg)
                                dual_pot_pkg::PH_ID: begin
                                    ack_next = (rx_byte[`TYPE_MSB:`TYPE_LSB] == DEVICE_TYPE_ID)
                                        && (rx_byte[`ADDR_MSB:`ADDR_LSB] == strap_sync)  // R3 R4
                                        && (busy_reg == '0);  // R16
                                    phase_next   = dual_pot_pkg::PH_INST;
                                    more_rx_next = 1'b1;
                                    more_tx_next = 1'b0;
                                end
                                dual_pot_pkg::PH_INST: begin
                                    ack_next     = 1'b1;  // R15
                                    phase_next   = dual_pot_pkg::PH_DATA;
                                    op_next      = rx_byte[`OP_MSB:`OP_LSB];
                                    sel_next     = rx_byte[`SEL_MSB:`SEL_LSB];
                                    pot_next     = rx_byte[`POT_BIT];
                                    more_rx_next = 1'b0;
                                    more_tx_next = 1'b0;
                                    unique case (rx_byte[`OP_MSB:`OP_LSB])
                                        `OP_RD_WIPER: begin
                                            more_tx_next = 1'b1;  // R9
                                            tx_next      = wiper_reg[rx_byte[`POT_BIT]];
                                        end
                                        `OP_RD_STORED: begin
                                            more_tx_next = 1'b1;
                                            tx_next      = stored_reg[rx_byte[`POT_BIT]]
                                                           [rx_byte[`SEL_MSB:`SEL_LSB]];
                                        end
                                        `OP_WR_WIPER, `OP_WR_STORED: more_rx_next = 1'b1;
                                        `OP_XFR_TO_WIPER: wiper_next[rx_byte[`POT_BIT]] =
                                            stored_reg[rx_byte[`POT_BIT]]
                                                      [rx_byte[`SEL_MSB:`SEL_LSB]];
                                        `OP_GXFR_TO_WIPER: begin
                                            wiper_next[0] =
                                                stored_reg[0][rx_byte[`SEL_MSB:`SEL_LSB]];
                                            wiper_next[1] =
                                                stored_reg[1][rx_byte[`SEL_MSB:`SEL_LSB]];
                                        end
                                        `OP_XFR_TO_STORE, `OP_GXFR_TO_STORE: pend_next = 1'b1;
                                        default: begin
                                        end
                                    endcase
                                end
                                default: begin
                                    ack_next     = 1'b1;  // R15
                                    more_rx_next = 1'b0;
                                    if (op_reg == `OP_WR_WIPER) begin
                                        wiper_next[pot_reg] = rx_byte;  // R9
                                    end else begin
                                        pend_next      = 1'b1;
                                        pend_data_next = rx_byte;
                                    end
                                end
                            endcase
                        end
                    end
                end
                dual_pot_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (!oe_reg) begin
                            if (ack_reg) begin
                                oe_next = 1'b1;  // R15
                            end else begin
                                state_next = dual_pot_pkg::ST_IDLE;  // R4 R16
                            end
                        end else if (more_tx_reg) begin
                            state_next = dual_pot_pkg::ST_SEND;
                            bit_next   = 3'h0;
                            oe_next    = ~tx_reg[7];  // R1 R2
                            tx_next    = {tx_reg[6:0], 1'b0};
                        end else begin
                            oe_next    = 1'b0;
                            bit_next   = 3'h0;
                            state_next = more_rx_reg ? dual_pot_pkg::ST_RECV
                                                     : dual_pot_pkg::ST_HOLD;
                        end
                    end
                end
                dual_pot_pkg::ST_SEND: begin
                    if (scl_rise) begin
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_next = dual_pot_pkg::ST_HOLD;
                        end
                    end else if (scl_fall) begin
                        oe_next = ~tx_reg[7];  // R11
                        tx_next = {tx_reg[6:0], 1'b0};
                    end
                end
                dual_pot_pkg::ST_HOLD: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;  // R11
                    end
                end
            endcase
        end
    end

    logic sda_out_reg;

    // Register the serial engine and potentiometer state
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state_reg     <= dual_pot_pkg::ST_IDLE;
            phase_reg     <= dual_pot_pkg::PH_ID;
            bit_reg       <= 3'h0;
            shift_reg     <= 8'h00;
            tx_reg        <= 8'h00;
            pend_data_reg <= 8'h00;
            op_reg        <= 4'h0;
            sel_reg       <= 2'h0;
            {pot_reg, ack_reg, oe_reg, more_rx_reg, more_tx_reg, pend_reg} <= 6'h00;
            sda_out_reg   <= 1'b0;
            for (int p = 0; p < 2; p++) begin
                wiper_reg[p] <= `WIPER_RESET;
                for (int r = 0; r < 4; r++) begin
                    stored_reg[p][r] <= `STORED_RESET;
                end
            end
        end else begin
            state_reg     <= state_next;
            phase_reg     <= phase_next;
            bit_reg       <= bit_next;
            shift_reg     <= shift_next;
            tx_reg        <= tx_next;
            pend_data_reg <= pend_data_next;
            op_reg        <= op_next;
            sel_reg       <= sel_next;
            {pot_reg, ack_reg, oe_reg, more_rx_reg, more_tx_reg, pend_reg} <=
                {pot_next, ack_next, oe_next, more_rx_next, more_tx_next, pend_next};
            sda_out_reg   <= 1'b0;  // R2
            wiper_reg     <= wiper_next;
            stored_reg    <= stored_next;
        end
    end

    assign SDA_OUT = sda_out_reg;
    assign SDA_OE  = oe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Nonvolatile write busy timer
    always_comb begin
        if (commit_nv) begin
            busy_next = `NV_CNT_W'(NV_WRITE_CYCLES);  // R16
        end else if (busy_reg != '0) begin
            busy_next = busy_reg - `NV_CNT_W'(1);
        end else begin
            busy_next = '0;
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            busy_reg <= '0;
        end else begin
            busy_reg <= busy_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tap selection, one per potentiometer
    dual_pot_pkg::tap_t tap_reg [2];
    dual_pot_pkg::tap_t tap_next [2];

    for (genvar p = 0; p < 2; p++) begin : g_pot  // R8
        always_comb begin
            tap_next[p] = decode_tap(wiper_reg[p]);  // R6 R7
        end
        always_ff @(posedge REF_CLK or posedge RESET) begin
            if (RESET) begin
                tap_reg[p] <= `TAP_RESET;
            end else begin
                tap_reg[p] <= tap_next[p];
            end
        end
    end

    assign TAP_SELECT_0 = tap_reg[0];
    assign TAP_SELECT_1 = tap_reg[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [63:0] stored_flat;
    assign stored_flat = {stored_reg[0][0], stored_reg[0][1], stored_reg[0][2], stored_reg[0][3],
                          stored_reg[1][0], stored_reg[1][1], stored_reg[1][2], stored_reg[1][3]};

    a_sda_never_high: assert property (@(posedge REF_CLK) disable iff (RESET)  // R2
        SDA_OE |-> !SDA_OUT) else $error("Data line driven high");
    a_oe_after_fall: assert property (@(posedge REF_CLK) disable iff (RESET)  // R1
        $changed(oe_reg) |-> $past(scl_fall || start_cond || stop_cond))
        else $error("Data output changed away from a clock fall");
    a_shift_on_rise: assert property (@(posedge REF_CLK) disable iff (RESET)  // R11
        $changed(shift_reg) |-> $past(scl_rise)) else $error("Bit taken off a rise");
    a_taps_onehot: assert property (@(posedge REF_CLK) disable iff (RESET)  // R6
        $onehot(tap_reg[0]) && $onehot(tap_reg[1])) else $error("Tap select not one-hot");
    a_tap_follows: assert property (@(posedge REF_CLK) disable iff (RESET)  // R7
        ##1 tap_reg[1][$past(wiper_reg[1])]) else $error("Tap does not match wiper");
    a_addr_match: assert property (@(posedge REF_CLK) disable iff (RESET)  // R4
        $rose(oe_reg) && phase_reg == dual_pot_pkg::PH_INST
        |-> shift_reg[3:0] == strap_sync && shift_reg[7:4] == DEVICE_TYPE_ID)
        else $error("Acknowledged a foreign address");
    a_wp_blocks: assert property (@(posedge REF_CLK) disable iff (RESET)  // R5
        !wp_sync |=> stored_flat == $past(stored_flat)) else $error("Write while protected");
    a_busy_no_ack: assert property (@(posedge REF_CLK) disable iff (RESET)  // R16
        busy_reg != '0 && phase_reg == dual_pot_pkg::PH_INST && state_reg == dual_pot_pkg::ST_ACK
        |-> !oe_reg) else $error("Address acknowledged while busy");
    a_commit_busy: assert property (@(posedge REF_CLK) disable iff (RESET)  // R16
        commit_nv |=> busy_reg == `NV_CNT_W'(NV_WRITE_CYCLES)) else $error("Busy not started");
    a_ack_drive: assert property (@(posedge REF_CLK) disable iff (RESET)  // R15
        state_reg == dual_pot_pkg::ST_ACK && ack_reg && !oe_reg && scl_fall && !start_cond
        |=> oe_reg [*2]) else $error("Acknowledge not driven");
    a_idle_wait: assert property (@(posedge REF_CLK) disable iff (RESET)  // R13
        state_reg == dual_pot_pkg::ST_IDLE && !start_cond |=> state_reg == dual_pot_pkg::ST_IDLE)
        else $error("Left idle without a start");
    a_start_resets: assert property (@(posedge REF_CLK) disable iff (RESET)  // R12
        start_cond |=> bit_reg == 3'h0 && state_reg == dual_pot_pkg::ST_RECV)
        else $error("Start not handled");
endmodule : dual_pot_slave
